// *** pkg/frr_pkg.sv ***
package frr_pkg;

  // widths
  localparam int unsigned FRR_BYTE_W = 8;
  localparam int unsigned FRR_UNIT_W = 16;
  localparam int unsigned FRR_CNT_W = 8;

  // command code of the over-voltage response byte
  localparam logic [7:0] FRR_CMD_OV_RESP = 8'h41;
  // response byte value after reset: disable, no retry, one unit
  localparam logic [7:0] FRR_CFG_RESET = 8'h80;

  // response modes, bits 7:6
  localparam logic [1:0] FRR_MODE_IGNORE = 2'h0;
  localparam logic [1:0] FRR_MODE_GRACE = 2'h1;
  localparam logic [1:0] FRR_MODE_RETRY = 2'h2;
  localparam logic [1:0] FRR_MODE_LATCH = 2'h3;

  // retry codes, bits 5:3
  localparam logic [2:0] FRR_RETRY_NONE = 3'h0;
  localparam logic [2:0] FRR_RETRY_FOREVER = 3'h7;

  // delay codes, bits 2:0, and their unit counts
  localparam logic [2:0] FRR_DLY_C0 = 3'h0;
  localparam logic [2:0] FRR_DLY_C1 = 3'h1;
  localparam logic [2:0] FRR_DLY_C2 = 3'h2;
  localparam logic [2:0] FRR_DLY_C3 = 3'h3;
  localparam logic [2:0] FRR_DLY_C4 = 3'h4;
  localparam logic [2:0] FRR_DLY_C5 = 3'h5;
  localparam logic [2:0] FRR_DLY_C6 = 3'h6;
  localparam logic [FRR_CNT_W-1:0] FRR_UNITS_C0 = 8'h01;
  localparam logic [FRR_CNT_W-1:0] FRR_UNITS_C1 = 8'h04;
  localparam logic [FRR_CNT_W-1:0] FRR_UNITS_C2 = 8'h04;
  localparam logic [FRR_CNT_W-1:0] FRR_UNITS_C3 = 8'h08;
  localparam logic [FRR_CNT_W-1:0] FRR_UNITS_C4 = 8'h10;
  localparam logic [FRR_CNT_W-1:0] FRR_UNITS_C5 = 8'h20;
  localparam logic [FRR_CNT_W-1:0] FRR_UNITS_C6 = 8'h40;
  localparam logic [FRR_CNT_W-1:0] FRR_UNITS_C7 = 8'h80;

  // counter constants
  localparam logic [FRR_CNT_W-1:0] FRR_CNT_ONE = 8'h01;
  localparam logic [FRR_CNT_W-1:0] FRR_CNT_ZERO = 8'h00;
  localparam logic [FRR_UNIT_W-1:0] FRR_UNIT_ONE = 16'h0001;
  localparam logic [FRR_UNIT_W-1:0] FRR_UNIT_ZERO = 16'h0000;

  // response byte layout: mode 7:6, retries 5:3, delay 2:0
  typedef struct packed {
    logic [1:0] mode;
    logic [2:0] retries;
    logic [2:0] delay;
  } frr_cfg_s;

  // byte command port from the bus transport
  typedef struct packed {
    logic wr;
    logic [7:0] code;
    logic [7:0] data;
  } frr_cmd_s;

  // sequencer states, gray along off-run-grace-wait-latch
  typedef enum logic [2:0] {
    FRR_ST_OFF = 3'b000,
    FRR_ST_RUN = 3'b001,
    FRR_ST_GRACE = 3'b011,
    FRR_ST_WAIT = 3'b010,
    FRR_ST_LATCH = 3'b110
  } frr_state_e;

endpackage : frr_pkg

// *** design/frr_delay_decode.sv ***
`timescale 1ns/1ps
module frr_delay_decode (
  // delay code in
  input wire logic [2:0] code,
  // unit count out
  output logic [frr_pkg::FRR_CNT_W-1:0] units
);
  import frr_pkg::*;

  // reserved code 2 maps onto the four-unit count, the nearest listed value
  always_comb begin
    unique case (code)
      FRR_DLY_C0: units = FRR_UNITS_C0;
      FRR_DLY_C1: units = FRR_UNITS_C1;
      FRR_DLY_C2: units = FRR_UNITS_C2;
      FRR_DLY_C3: units = FRR_UNITS_C3;
      FRR_DLY_C4: units = FRR_UNITS_C4;
      FRR_DLY_C5: units = FRR_UNITS_C5;
      FRR_DLY_C6: units = FRR_UNITS_C6;
      default: units = FRR_UNITS_C7;
    endcase
  end

endmodule : frr_delay_decode

// *** design/frr_timer.sv ***
`timescale 1ns/1ps
module frr_timer (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // control
  input wire logic start,
  input wire logic [frr_pkg::FRR_CNT_W-1:0] units,
  input wire logic [frr_pkg::FRR_UNIT_W-1:0] unit_cycles,
  // status
  output logic busy,
  output logic done
);
  import frr_pkg::*;

  logic [FRR_UNIT_W-1:0] pre;
  logic [FRR_UNIT_W-1:0] next_pre;
  logic [FRR_CNT_W-1:0] left;
  logic [FRR_CNT_W-1:0] next_left;
  logic next_busy;
  logic next_done;
  logic [FRR_UNIT_W-1:0] span;
  logic tick;

  // a zero unit length would wrap the prescaler through its full 16-bit range, so it counts as one cycle
  assign span = (unit_cycles == FRR_UNIT_ZERO) ? FRR_UNIT_ONE : unit_cycles;
  assign tick = busy && (pre == FRR_UNIT_ONE);

  // prescaler gives one unit tick, unit counter ends the delay
  always_comb begin
    next_pre = pre;
    next_left = left;
    next_busy = busy;
    next_done = 1'b0;
    if (start) begin
      next_pre = span;
      next_left = units;
      next_busy = 1'b1;
    end else if (tick) begin
      next_pre = span;
      next_left = left - FRR_CNT_ONE;
      if (left == FRR_CNT_ONE) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end else if (busy) begin
      next_pre = pre - FRR_UNIT_ONE;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pre <= FRR_UNIT_ZERO;
      left <= FRR_CNT_ZERO;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      pre <= next_pre;
      left <= next_left;
      busy <= next_busy;
      done <= next_done;
    end
  end

endmodule : frr_timer

// *** design/frr_top.sv ***
`timescale 1ns/1ps
// Operation
// - mode 10 disables output, then follows retries
// - mode 11 holds output off until cleared
// - clear, clear-all, reset, off-on cycle clear latch
// - retry code 000 means latch, no restart
// - codes 1-6 retry that often, then latch
// - restart starts spaced by delay times unit
// - code 111 retries until off or shutdown
// - retry count from response bits 5:3
// - delay code decodes to 1,4,8..128 units
// - delay is grace time or retry spacing
// - unit length comes from separate register
// - mode 00 ignores fault, keeps running
// - mode 01 runs for delay, then retries
module frr_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // byte command port
  input wire frr_pkg::frr_cmd_s cmd,
  input wire logic rd_req,
  input wire logic [7:0] rd_code,
  output logic [7:0] rd_data,
  // fault clearing commands
  input wire logic clear_faults,
  input wire logic status_clr,
  // on/off sources
  input wire logic ctrl_pin,
  input wire logic on_cmd,
  // fault inputs and unit length
  input wire logic fault_det,
  input wire logic other_fault,
  input wire logic [frr_pkg::FRR_UNIT_W-1:0] unit_cycles,
  // outputs
  output logic out_en,
  output logic ov_fault_flag,
  output frr_pkg::frr_state_e state
);
  import frr_pkg::*;

  // configuration byte
  frr_cfg_s cfg;
  frr_cfg_s next_cfg;
  logic [7:0] next_rd_data;

  // pin synchroniser and qualified pin level
  logic ctrl_s1;
  logic ctrl_s2;
  logic ctrl_s3;
  logic ctrl_q;
  logic next_ctrl_q;

  // sequencer state
  frr_state_e next_state;
  logic [FRR_CNT_W-1:0] tries_left;
  logic [FRR_CNT_W-1:0] next_tries_left;
  logic retry_active;
  logic next_retry_active;
  logic next_out_en;
  logic next_ov_fault_flag;
  logic tmr_start;
  logic tmr_busy;
  logic tmr_done;
  logic [FRR_CNT_W-1:0] delay_units;
  logic enable;
  logic clear_evt;
  logic exhausted;

  // command writes land in the response byte; reads are registered
  always_comb begin
    next_cfg = cfg;
    next_rd_data = rd_data;
    if (cmd.wr && cmd.code == FRR_CMD_OV_RESP) begin
      next_cfg = frr_cfg_s'(cmd.data);
    end
    if (rd_req) begin
      next_rd_data = (rd_code == FRR_CMD_OV_RESP) ? 8'(cfg) : 8'h00;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cfg <= frr_cfg_s'(FRR_CFG_RESET);
      rd_data <= 8'h00;
    end else begin
      cfg <= next_cfg;
      rd_data <= next_rd_data;
    end
  end

  // the pin is asynchronous; only agreeing late stages update its level
  always_comb begin
    next_ctrl_q = ctrl_q;
    if (ctrl_s2 == ctrl_s3) begin
      next_ctrl_q = ctrl_s3;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_s1 <= 1'b0;
      ctrl_s2 <= 1'b0;
      ctrl_s3 <= 1'b0;
      ctrl_q <= 1'b0;
    end else begin
      ctrl_s1 <= ctrl_pin;
      ctrl_s2 <= ctrl_s1;
      ctrl_s3 <= ctrl_s2;
      ctrl_q <= next_ctrl_q;
    end
  end

  // both pin and command must ask for the output to be on
  assign enable = ctrl_q && on_cmd;
  assign clear_evt = clear_faults || status_clr;
  // unlimited code never runs out of attempts
  assign exhausted = retry_active && (tries_left == FRR_CNT_ZERO)
    && (cfg.retries != FRR_RETRY_FOREVER);

  frr_delay_decode u_decode (
    .code(cfg.delay),
    .units(delay_units)
  );

  // one unit length shared by grace and spacing delays
  frr_timer u_timer (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .start(tmr_start),
    .units(delay_units),
    .unit_cycles(unit_cycles),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // sequencer: off drops the output and the retry episode, other faults stop retries
  always_comb begin
    next_state = state;
    next_tries_left = tries_left;
    next_retry_active = retry_active;
    tmr_start = 1'b0;
    if (!enable) begin
      next_state = FRR_ST_OFF;
      next_retry_active = 1'b0;
    end else if (other_fault) begin
      next_state = FRR_ST_LATCH;
    end else begin
      unique case (state)
        FRR_ST_OFF: begin
          // off then on clears any latched fault
          next_state = FRR_ST_RUN;
          next_retry_active = 1'b0;
        end
        FRR_ST_RUN: begin
          if (fault_det) begin
            unique case (cfg.mode)
              FRR_MODE_IGNORE: next_state = FRR_ST_RUN;
              FRR_MODE_GRACE: begin
                next_state = FRR_ST_GRACE;
                tmr_start = 1'b1;
              end
              FRR_MODE_RETRY: begin
                if (cfg.retries == FRR_RETRY_NONE || exhausted) begin
                  next_state = FRR_ST_LATCH;
                end else begin
                  next_state = FRR_ST_WAIT;
                  tmr_start = 1'b1;
                  if (!retry_active) begin
                    next_tries_left = FRR_CNT_W'(cfg.retries);
                    next_retry_active = 1'b1;
                  end
                end
              end
              default: next_state = FRR_ST_LATCH;
            endcase
          end else if (tmr_done) begin
            // a restart that survives one delay ends the episode
            next_retry_active = 1'b0;
          end
        end
        FRR_ST_GRACE: begin
          if (tmr_done) begin
            if (!fault_det) begin
              next_state = FRR_ST_RUN;
            end else if (cfg.retries == FRR_RETRY_NONE || exhausted) begin
              next_state = FRR_ST_LATCH;
            end else begin
              next_state = FRR_ST_WAIT;
              tmr_start = 1'b1;
              if (!retry_active) begin
                next_tries_left = FRR_CNT_W'(cfg.retries);
                next_retry_active = 1'b1;
              end
            end
          end
        end
        FRR_ST_WAIT: begin
          if (tmr_done) begin
            next_state = FRR_ST_RUN;
            tmr_start = 1'b1;
            if (cfg.retries != FRR_RETRY_FOREVER) begin
              next_tries_left = tries_left - FRR_CNT_ONE;
            end
          end
        end
        FRR_ST_LATCH: begin
          if (clear_evt) begin
            next_state = FRR_ST_RUN;
            next_retry_active = 1'b0;
          end
        end
        default: next_state = FRR_ST_OFF;
      endcase
    end
    next_out_en = (next_state == FRR_ST_RUN) || (next_state == FRR_ST_GRACE);
    // a new detection wins over a clear in the same cycle
    next_ov_fault_flag = (ov_fault_flag && !clear_evt) || fault_det;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= FRR_ST_OFF;
      tries_left <= FRR_CNT_ZERO;
      retry_active <= 1'b0;
      out_en <= 1'b0;
      ov_fault_flag <= 1'b0;
    end else begin
      state <= next_state;
      tries_left <= next_tries_left;
      retry_active <= next_retry_active;
      out_en <= next_out_en;
      ov_fault_flag <= next_ov_fault_flag;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // a fault seen in RUN while on and free of other faults
  logic run_ok;
  assign run_ok = enable && !other_fault && state == FRR_ST_RUN && fault_det;

  mode10_disable_a: assert property (
    run_ok && cfg.mode == FRR_MODE_RETRY |=> !out_en && state != FRR_ST_RUN)
    else $error("mode 10 fault did not disable output");
  latch_hold_a: assert property (
    state == FRR_ST_LATCH && enable && !clear_evt |=> state == FRR_ST_LATCH && !out_en)
    else $error("latched fault released without clear");
  clear_exit_a: assert property (
    state == FRR_ST_LATCH && enable && !other_fault && clear_evt |=> out_en)
    else $error("clear did not release latch");
  no_retry_a: assert property (
    run_ok && cfg.mode == FRR_MODE_RETRY && cfg.retries == FRR_RETRY_NONE
    |=> state == FRR_ST_LATCH)
    else $error("retry code 000 attempted restart");
  exhaust_latch_a: assert property (
    run_ok && cfg.mode == FRR_MODE_RETRY && exhausted |=> state == FRR_ST_LATCH)
    else $error("exhausted retries did not latch");
  spacing_start_a: assert property (
    state == FRR_ST_WAIT && enable && !other_fault |-> tmr_busy || tmr_done)
    else $error("retry wait without running timer");
  forever_retry_a: assert property (
    run_ok && cfg.mode == FRR_MODE_RETRY && cfg.retries == FRR_RETRY_FOREVER
    |=> state == FRR_ST_WAIT)
    else $error("unlimited retry stopped");
  delay_decode_a: assert property (
    cfg.delay == FRR_DLY_C6 |-> delay_units == FRR_UNITS_C6)
    else $error("delay code 6 decoded wrongly");
  ignore_run_a: assert property (
    run_ok && cfg.mode == FRR_MODE_IGNORE |=> out_en && state == FRR_ST_RUN)
    else $error("ignored fault interrupted output");
  grace_on_a: assert property (
    run_ok && cfg.mode == FRR_MODE_GRACE |=> out_en && state == FRR_ST_GRACE)
    else $error("grace mode did not keep running");
  off_drop_a: assert property (
    !enable |=> !out_en && state == FRR_ST_OFF)
    else $error("output on while commanded off");

  // status flag, episode load and delay use
  flag_set_a: assert property (
    fault_det |=> ov_fault_flag)
    else $error("fault detect did not set status flag");
  flag_clear_a: assert property (
    clear_evt && !fault_det |=> !ov_fault_flag)
    else $error("clear did not drop status flag");
  retry_load_a: assert property (
    run_ok && cfg.mode == FRR_MODE_RETRY && !retry_active && cfg.retries != FRR_RETRY_NONE
    |=> tries_left == FRR_CNT_W'($past(cfg.retries)))
    else $error("retry count not loaded from response byte");
  grace_timer_a: assert property (
    run_ok && cfg.mode == FRR_MODE_GRACE |=> tmr_busy)
    else $error("grace delay timer not started");
  wait_dark_a: assert property (
    state == FRR_ST_WAIT |-> !out_en)
    else $error("output on during retry wait");
  reserved_code_a: assert property (
    cfg.delay == FRR_DLY_C2 |-> delay_units == FRR_UNITS_C2)
    else $error("reserved delay code decoded wrongly");
  endless_count_a: assert property (
    cfg.retries == FRR_RETRY_FOREVER |-> !exhausted)
    else $error("unlimited retry ran out of attempts");

endmodule : frr_top

// *** tb/frr_stage_model.sv ***
`timescale 1ns/1ps
// power stage plus limit comparator seen from the sequencer
module frr_stage_model (
  // stage control
  input wire logic out_en,
  input wire logic ov_force,
  // comparator result
  output logic fault_det
);
  // an over-voltage can only be seen while the stage switches,
  // so a disabled output never reports a fault
  assign fault_det = out_en & ov_force;
endmodule : frr_stage_model

// *** tb/fault_retry_responder_tb_top.sv ***
`timescale 1ns/1ps
module fault_retry_responder_tb_top;
  import frr_pkg::*;
  // stimulus
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  frr_cmd_s cmd = '0;
  logic rd_req = 1'b0;
  logic [7:0] rd_code = 8'h00;
  logic clear_faults = 1'b0;
  logic status_clr = 1'b0;
  logic ctrl_pin = 1'b0;
  logic on_cmd = 1'b0;
  logic other_fault = 1'b0;
  logic ov_force = 1'b0;
  logic [FRR_UNIT_W-1:0] unit_cycles = 16'h0001;
  // observed
  logic [7:0] rd_data;
  logic out_en;
  logic ov_fault_flag;
  logic fault_det;
  frr_state_e state;
  int n_errors = 0;
  int compares = 0;
  // unit counts per delay code; code 2 taken as four
  int units_tab [8] = '{1, 4, 4, 8, 16, 32, 64, 128};
  int n;
  int rises;

  // 20 MHz system clock
  always #25 clk_sys = ~clk_sys;

  frr_top dut (.clk_sys(clk_sys), .reset_n(reset_n), .cmd(cmd), .rd_req(rd_req),
    .rd_code(rd_code), .rd_data(rd_data), .clear_faults(clear_faults),
    .status_clr(status_clr), .ctrl_pin(ctrl_pin), .on_cmd(on_cmd), .fault_det(fault_det),
    .other_fault(other_fault), .unit_cycles(unit_cycles), .out_en(out_en),
    .ov_fault_flag(ov_fault_flag), .state(state));

  frr_stage_model stage (.out_en(out_en), .ov_force(ov_force), .fault_det(fault_det));

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask : check

  task automatic tally_and_finish;
    if (n_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  // one-cycle write strobe of the response byte
  task automatic write_cfg(input logic [7:0] d);
    @(posedge clk_sys);
    cmd <= '{wr: 1'b1, code: FRR_CMD_OV_RESP, data: d};
    @(posedge clk_sys);
    cmd.wr <= 1'b0;
  endtask : write_cfg

  task automatic read_reg(input logic [7:0] c, input logic [7:0] exp);
    @(posedge clk_sys);
    rd_req <= 1'b1;
    rd_code <= c;
    @(posedge clk_sys);
    rd_req <= 1'b0;
    #1;
    check("rd_data", {8'h00, exp}, {8'h00, rd_data});
  endtask : read_reg

  // bounded wait for the output enable; cnt is edges spent waiting
  task automatic wait_en(input logic v, output int cnt);
    cnt = 0;
    #1;
    while (out_en !== v && cnt < 800) begin
      @(posedge clk_sys);
      #1;
      cnt++;
    end
    check("out_en", {15'h0, v}, {15'h0, out_en});
  endtask : wait_en

  // restarts seen until the sequencer latches or the limit runs out
  task automatic count_rises(input int limit, output int r);
    logic prev;
    int k;
    r = 0;
    #1;
    prev = out_en;
    for (k = 0; k < limit && state !== FRR_ST_LATCH; k++) begin
      @(posedge clk_sys);
      #1;
      if (out_en === 1'b1 && prev === 1'b0) r++;
      prev = out_en;
    end
  endtask : count_rises

  // off/on cycle also ends any retry episode, so tests start clean
  task automatic recover;
    @(posedge clk_sys);
    ov_force <= 1'b0;
    other_fault <= 1'b0;
    on_cmd <= 1'b0;
    clear_faults <= 1'b1;
    @(posedge clk_sys);
    clear_faults <= 1'b0;
    repeat (2) @(posedge clk_sys);
    on_cmd <= 1'b1;
    wait_en(1'b1, n);
  endtask : recover

  // main sequence
  initial begin
    int i;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    read_reg(FRR_CMD_OV_RESP, FRR_CFG_RESET);
    read_reg(8'h42, 8'h00);
    @(posedge clk_sys);
    ctrl_pin <= 1'b1;
    on_cmd <= 1'b1;
    wait_en(1'b1, n);
    // ignore mode keeps running, flag still records
    write_cfg(8'h07);
    read_reg(FRR_CMD_OV_RESP, 8'h07);
    @(posedge clk_sys);
    ov_force <= 1'b1;
    repeat (40) @(posedge clk_sys);
    #1;
    check("out_en", 16'h1, {15'h0, out_en});
    check("flag", 16'h1, {15'h0, ov_fault_flag});
    recover;
    check("flag", 16'h0, {15'h0, ov_fault_flag});
    // latch mode, then each way of clearing it
    for (i = 0; i < 5; i++) begin
      write_cfg(8'hC7);
      @(posedge clk_sys);
      ov_force <= 1'b1;
      @(posedge clk_sys);
      ov_force <= 1'b0;
      repeat (20) @(posedge clk_sys);
      #1;
      check("state", {13'h0, FRR_ST_LATCH}, {13'h0, state});
      check("out_en", 16'h0, {15'h0, out_en});
      @(posedge clk_sys);
      case (i)
        0: clear_faults <= 1'b1;
        1: status_clr <= 1'b1;
        2: on_cmd <= 1'b0;
        3: reset_n <= 1'b0;
        default: ctrl_pin <= 1'b0;
      endcase
      // the pin filter needs the low level to stand a few cycles
      repeat ((i == 4) ? 6 : 1) @(posedge clk_sys);
      clear_faults <= 1'b0;
      status_clr <= 1'b0;
      on_cmd <= 1'b1;
      ctrl_pin <= 1'b1;
      reset_n <= 1'b1;
      wait_en(1'b1, n);
    end
    // disable and retry, retry codes 000 to 110 with a fault that stays
    for (i = 0; i < 7; i++) begin
      write_cfg({2'b10, i[2:0], 3'b000});
      @(posedge clk_sys);
      ov_force <= 1'b1;
      count_rises(3000, rises);
      check("restarts", 16'(i), 16'(rises));
      check("state", {13'h0, FRR_ST_LATCH}, {13'h0, state});
      recover;
    end
    // endless retry, stopped here by another fault
    write_cfg(8'hB8);
    @(posedge clk_sys);
    ov_force <= 1'b1;
    count_rises(400, rises);
    check("endless", 16'h1, {15'h0, rises > 20});
    @(posedge clk_sys);
    other_fault <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    check("out_en", 16'h0, {15'h0, out_en});
    recover;
    // restart spacing over every delay code
    @(posedge clk_sys);
    unit_cycles <= 16'h0002;
    for (i = 0; i < 8; i++) begin
      write_cfg({2'b10, 3'b001, i[2:0]});
      @(posedge clk_sys);
      ov_force <= 1'b1;
      wait_en(1'b0, n);
      wait_en(1'b1, n);
      // restart lands one edge after the last unit ends
      check("spacing", 16'(units_tab[i] * 2 + 1), 16'(n));
      recover;
    end
    // unit length scales the same delay code
    @(posedge clk_sys);
    unit_cycles <= 16'h0003;
    write_cfg(8'h89);
    @(posedge clk_sys);
    ov_force <= 1'b1;
    wait_en(1'b0, n);
    wait_en(1'b1, n);
    check("unit", 16'(units_tab[1] * 3 + 1), 16'(n));
    recover;
    // grace period: output stays up for the delay, code 3 runs 7 units longer
    for (i = 0; i < 2; i++) begin
      write_cfg({2'b01, 3'b001, (i == 0) ? 3'h0 : 3'h3});
      @(posedge clk_sys);
      ov_force <= 1'b1;
      wait_en(1'b0, n);
      // grace spans the units plus the start edge and the decision edge
      check("grace", 16'(units_tab[(i == 0) ? 0 : 3] * 3 + 2), 16'(n));
      recover;
    end
    // fault gone before the grace ends: no shutdown
    write_cfg(8'h4B);
    @(posedge clk_sys);
    ov_force <= 1'b1;
    repeat (3) @(posedge clk_sys);
    ov_force <= 1'b0;
    repeat (60) @(posedge clk_sys);
    #1;
    check("state", {13'h0, FRR_ST_RUN}, {13'h0, state});
    tally_and_finish;
  end

  // hang guard, well beyond the expected run
  initial begin
    #3000000;
    n_errors++;
    tally_and_finish;
  end
endmodule : fault_retry_responder_tb_top
